// [ras_pkg.sv]
`default_nettype none
// Shared constants and types of the return address stack.
package ras_pkg;
	// Geometry of the stack and the program counter.
	localparam int PC_W = 21;
	localparam int PTR_W = 5;
	localparam int STACK_DEPTH = 31;
	localparam int FETCH_W = 16;
	localparam int SHADOW_W = 8;
	localparam int WB_AW = 8;
	localparam int WB_DW = 32;

	// Pointer landmarks: zero has no storage, 30 -> 31 is the filling push.
	localparam logic [4:0] PTR_RESET = 5'h00;
	localparam logic [4:0] PTR_FULL_EDGE = 5'h1E;
	localparam logic [4:0] PTR_TOP = 5'h1F;
	localparam logic [4:0] PTR_STEP = 5'h01;

	// Vectors and program space.
	localparam logic [20:0] RESET_VECTOR = 21'h000000;
	localparam logic [20:0] HIGH_VECTOR = 21'h000008;
	localparam logic [20:0] LOW_VECTOR = 21'h000018;
	localparam logic [20:0] FULL_PC_STEP = 21'h000002;
	localparam logic [20:0] IMPL_BYTES = 21'h008000;

	// Register byte addresses on the bus.
	localparam logic [7:0] OFF_POINTER = 8'h00;
	localparam logic [7:0] OFF_TOP_UPPER = 8'h04;
	localparam logic [7:0] OFF_TOP_HIGH = 8'h08;
	localparam logic [7:0] OFF_TOP_LOW = 8'h0C;
	localparam logic [7:0] OFF_CONFIG = 8'h10;

	// Field positions and reset values.
	localparam int FULL_BIT = 7;
	localparam int UNDERFLOW_BIT = 6;
	localparam int ERR_RESET_BIT = 0;
	localparam logic ERR_RESET_RESET = 1'b1;

	// Requests from the instruction sequencer.
	typedef enum logic [3:0] {
		RAS_OP_NONE,
		RAS_OP_CALL,
		RAS_OP_CALL_FAST,
		RAS_OP_INT_HIGH,
		RAS_OP_INT_LOW,
		RAS_OP_RETURN,
		RAS_OP_RETURN_FAST,
		RAS_OP_PUSH,
		RAS_OP_POP
	} ras_op_t;
endpackage
`default_nettype wire

// [ras_return_address_stack.sv]
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ras_return_address_stack (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic sysReset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic seqValid,
	input wire ras_pkg::ras_op_t seqOp,
	input wire logic [20:0] seqPc,
	input wire logic [7:0] statusIn,
	input wire logic [7:0] workIn,
	input wire logic [7:0] bankIn,
	output logic pcLoad,
	output logic [20:0] pcNext,
	output logic restoreLoad,
	output logic [7:0] statusOut,
	output logic [7:0] workOut,
	output logic [7:0] bankOut,
	output logic devResetReq,
	input wire logic [20:0] fetchAddr,
	input wire logic [15:0] romData,
	output logic [15:0] fetchData
);

	// Address match used by every register decode.
	function automatic logic hitReg(input logic [7:0] adr, input logic [7:0] off);
		hitReg = (adr == off);
	endfunction

	// Storage: index zero has no entry behind it.
	logic [20:0] stackMem [1:ras_pkg::STACK_DEPTH];
	logic [4:0] ptr_q;
	logic [4:0] ptr_d;
	logic full_q;
	logic full_d;
	logic under_q;
	logic under_d;
	logic errResetEn_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic pcLoad_q;
	logic pcLoad_d;
	logic [20:0] pcNext_q;
	logic [20:0] pcNext_d;
	logic devReset_q;
	logic restoreLoad_q;
	logic [7:0] shStatus_q;
	logic [7:0] shWork_q;
	logic [7:0] shBank_q;
	logic [7:0] statusOut_q;
	logic [7:0] workOut_q;
	logic [7:0] bankOut_q;
	logic [15:0] fetchData_q;

	// Request classes from the sequencer.
	wire isInt = seqValid && (seqOp == ras_pkg::RAS_OP_INT_HIGH || seqOp == ras_pkg::RAS_OP_INT_LOW);
	wire isCall = seqValid && (seqOp == ras_pkg::RAS_OP_CALL || seqOp == ras_pkg::RAS_OP_CALL_FAST);
	wire isRet = seqValid && (seqOp == ras_pkg::RAS_OP_RETURN || seqOp == ras_pkg::RAS_OP_RETURN_FAST);
	wire isExplPush = seqValid && seqOp == ras_pkg::RAS_OP_PUSH;
	wire isExplPop = seqValid && seqOp == ras_pkg::RAS_OP_POP;
	wire isPushOp = isCall || isInt || isExplPush;
	wire isPopOp = isRet || isExplPop;
	wire isShadowLoad = isInt || (seqValid && seqOp == ras_pkg::RAS_OP_CALL_FAST);

	// Stack condition decode.
	wire atZero = (ptr_q == ras_pkg::PTR_RESET);
	wire atTop = (ptr_q == ras_pkg::PTR_TOP);
	wire pushFull = isPushOp && (ptr_q == ras_pkg::PTR_FULL_EDGE);
	wire pushBlocked = isPushOp && atTop;
	wire popUnder = isPopOp && atZero;
	wire errEvent = errResetEn_q && (pushFull || popUnder);
	wire [20:0] pushValue = (pushFull && errResetEn_q) ? seqPc + ras_pkg::FULL_PC_STEP : seqPc;
	wire [20:0] topEntry = atZero ? 21'h000000 : stackMem[ptr_q];

	// Bus decode: the sequencer owns the stack in any cycle it asks, so a bus
	// access waits; this keeps a push and a top write from hitting one entry.
	wire busReq = wb_cyc_i && wb_stb_i && !ack_q && !seqValid;
	wire busWr = busReq && wb_we_i && wb_sel_i[0];
	wire selPtr = hitReg(wb_adr_i, ras_pkg::OFF_POINTER);
	wire selUp = hitReg(wb_adr_i, ras_pkg::OFF_TOP_UPPER);
	wire selHi = hitReg(wb_adr_i, ras_pkg::OFF_TOP_HIGH);
	wire selLo = hitReg(wb_adr_i, ras_pkg::OFF_TOP_LOW);
	wire selCfg = hitReg(wb_adr_i, ras_pkg::OFF_CONFIG);
	wire ptrWr = busWr && selPtr;
	wire tosWr = busWr && (selUp || selHi || selLo) && !atZero;
	wire [20:0] tosMerged = {selUp ? wb_dat_i[4:0] : topEntry[20:16],
		selHi ? wb_dat_i[7:0] : topEntry[15:8],
		selLo ? wb_dat_i[7:0] : topEntry[7:0]};

	// Single write port: a push writes the slot above the old pointer.
	wire memWe = (isPushOp && !pushBlocked) || tosWr;
	wire [4:0] memAddr = isPushOp ? ptr_q + ras_pkg::PTR_STEP : ptr_q;
	wire [20:0] memData = isPushOp ? pushValue : tosMerged;

	// The array has no reset; pointer zero guards every read of stale words.
	always_ff @(posedge ref_clk)
	begin
		if (memWe)
			stackMem[memAddr] <= memData;
	end

	// Pointer next value; a stack error with the reset option drops it to zero.
	always_comb
	begin
		ptr_d = ptr_q;
		if (sysReset || errEvent)
			ptr_d = ras_pkg::PTR_RESET;
		else if (isPushOp && !atTop)
			ptr_d = ptr_q + ras_pkg::PTR_STEP;
		else if (isPopOp && !atZero)
			ptr_d = ptr_q - ras_pkg::PTR_STEP;
		else if (ptrWr)
			ptr_d = wb_dat_i[4:0];
	end

	// Flags: a write of zero clears, a hardware set in the same cycle wins.
	assign full_d = (full_q && !(ptrWr && !wb_dat_i[ras_pkg::FULL_BIT]))
		|| pushFull || pushBlocked;
	assign under_d = (under_q && !(ptrWr && !wb_dat_i[ras_pkg::UNDERFLOW_BIT]))
		|| popUnder;

	// Read mux; bit 5 of the pointer register and unmapped words read zero.
	always_comb
	begin
		rdata_d = 32'h00000000;
		if (selPtr)
			rdata_d = {24'h000000, full_q, under_q, 1'b0, ptr_q};
		else if (selUp)
			rdata_d = {27'h0000000, topEntry[20:16]};
		else if (selHi)
			rdata_d = {24'h000000, topEntry[15:8]};
		else if (selLo)
			rdata_d = {24'h000000, topEntry[7:0]};
		else if (selCfg)
			rdata_d = {31'h00000000, errResetEn_q};
	end

	// Program counter requests: vectors, returns, and the reset vector after
	// any reset. A call loads the PC only through a stack error reset; the PC latches live outside.
	always_comb
	begin
		pcLoad_d = 1'b0;
		pcNext_d = pcNext_q;
		if (sysReset || errEvent)
		begin
			pcLoad_d = 1'b1;
			pcNext_d = ras_pkg::RESET_VECTOR;
		end
		else if (seqValid && seqOp == ras_pkg::RAS_OP_INT_HIGH)
		begin
			pcLoad_d = 1'b1;
			pcNext_d = ras_pkg::HIGH_VECTOR;
		end
		else if (seqValid && seqOp == ras_pkg::RAS_OP_INT_LOW)
		begin
			pcLoad_d = 1'b1;
			pcNext_d = ras_pkg::LOW_VECTOR;
		end
		else if (isRet)
		begin
			pcLoad_d = 1'b1;
			pcNext_d = topEntry;
		end
	end

	// Flags survive every reset except power-on.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			full_q <= 1'b0;
			under_q <= 1'b0;
		end
		else
		begin
			full_q <= full_d;
			under_q <= under_d;
		end
	end

	// Pointer and configuration.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ptr_q <= ras_pkg::PTR_RESET;
			errResetEn_q <= ras_pkg::ERR_RESET_RESET;
		end
		else
		begin
			ptr_q <= ptr_d;
			if (busWr && selCfg)
				errResetEn_q <= wb_dat_i[ras_pkg::ERR_RESET_BIT];
		end
	end

	// Bus answer: ack one cycle after the request is taken, then dropped.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= busReq;
			if (busReq)
				rdata_q <= rdata_d;
		end
	end

	// Sequencer answers; the load pulse is high during reset so the core
	// starts at the reset vector.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pcLoad_q <= 1'b1;
			pcNext_q <= ras_pkg::RESET_VECTOR;
			devReset_q <= 1'b0;
		end
		else
		begin
			pcLoad_q <= pcLoad_d;
			pcNext_q <= pcNext_d;
			devReset_q <= errEvent;
		end
	end

	// One-deep shadows: a later interrupt simply overwrites an earlier save.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			shStatus_q <= 8'h00;
			shWork_q <= 8'h00;
			shBank_q <= 8'h00;
			restoreLoad_q <= 1'b0;
			statusOut_q <= 8'h00;
			workOut_q <= 8'h00;
			bankOut_q <= 8'h00;
		end
		else
		begin
			if (isShadowLoad)
			begin
				shStatus_q <= statusIn;
				shWork_q <= workIn;
				shBank_q <= bankIn;
			end
			restoreLoad_q <= seqValid && seqOp == ras_pkg::RAS_OP_RETURN_FAST;
			if (seqValid && seqOp == ras_pkg::RAS_OP_RETURN_FAST)
			begin
				statusOut_q <= shStatus_q;
				workOut_q <= shWork_q;
				bankOut_q <= shBank_q;
			end
		end
	end

	// Unimplemented program space reads as zero, which decodes as a no-op.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			fetchData_q <= 16'h0000;
		else
			fetchData_q <= (fetchAddr < ras_pkg::IMPL_BYTES) ? romData : 16'h0000;
	end

	// Outputs straight from the flip-flops.
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;
	assign pcLoad = pcLoad_q;
	assign pcNext = pcNext_q;
	assign restoreLoad = restoreLoad_q;
	assign statusOut = statusOut_q;
	assign workOut = workOut_q;
	assign bankOut = bankOut_q;
	assign devResetReq = devReset_q;
	assign fetchData = fetchData_q;

	// Checks of the stack behaviour.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	property p_push_write;
		isPushOp && ptr_q < ras_pkg::PTR_FULL_EDGE && !sysReset
			|=> ptr_q == $past(ptr_q) + 5'h01 && stackMem[ptr_q] == $past(seqPc);
	endproperty
	a_push_write: assert property (p_push_write) else $error("push did not store PC");

	property p_return_pop;
		isRet && !atZero && !sysReset
			|=> pcLoad_q && pcNext_q == $past(topEntry) && ptr_q == $past(ptr_q) - 5'h01;
	endproperty
	a_return_pop: assert property (p_return_pop) else $error("return pop wrong");

	property p_full_flag;
		pushFull |=> full_q;
	endproperty
	a_full_flag: assert property (p_full_flag) else $error("full flag not set");

	property p_full_stick;
		isPushOp && atTop && !sysReset && !errResetEn_q
			|=> ptr_q == 5'h1F && stackMem[31] == $past(stackMem[31]);
	endproperty
	a_full_stick: assert property (p_full_stick) else $error("full stack moved");

	property p_err_reset;
		pushFull && errResetEn_q
			|=> devReset_q && ptr_q == 5'h00 && stackMem[31] == $past(seqPc) + 21'h000002
			##1 !devReset_q;
	endproperty
	a_err_reset: assert property (p_err_reset) else $error("stack error reset wrong");

	property p_underflow;
		isRet && atZero |=> under_q && ptr_q == 5'h00 && pcNext_q == 21'h000000;
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow handling wrong");

	property p_flags_sticky;
		sysReset && !ptrWr |=> (full_q || !$past(full_q)) && (under_q || !$past(under_q));
	endproperty
	a_flags_sticky: assert property (p_flags_sticky) else $error("flag lost on reset");

	property p_int_vector;
		seqValid && seqOp == ras_pkg::RAS_OP_INT_HIGH && !sysReset && !errEvent
			|=> pcLoad_q && pcNext_q == 21'h000008;
	endproperty
	a_int_vector: assert property (p_int_vector) else $error("high vector wrong");

	property p_fast_restore;
		isShadowLoad ##1 (seqValid && seqOp == ras_pkg::RAS_OP_RETURN_FAST)
			|=> restoreLoad_q && statusOut_q == $past(statusIn, 2)
			&& workOut_q == $past(workIn, 2) && bankOut_q == $past(bankIn, 2);
	endproperty
	a_fast_restore: assert property (p_fast_restore) else $error("fast restore wrong");

	property p_fetch_zero;
		fetchAddr >= ras_pkg::IMPL_BYTES |=> fetchData_q == 16'h0000;
	endproperty
	a_fetch_zero: assert property (p_fetch_zero) else $error("fetch beyond memory not zero");

	property p_bus_ack;
		busReq |=> ack_q ##1 !ack_q;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("bus ack timing wrong");

	c_full_push: cover property (pushFull);
	c_underflow: cover property (popUnder);
	c_fast_pair: cover property (isShadowLoad ##[1:20] restoreLoad_q);
	c_tos_write: cover property (tosWr);

endmodule
`default_nettype wire

// [ras_seq_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Sequencer stand-in: one stack request per issue call, two per issuePair, answer captured after the last.
module ras_seq_model (
	input wire logic ref_clk,
	output logic seqValid,
	output ras_pkg::ras_op_t seqOp,
	output logic [20:0] seqPc,
	input wire logic pcLoad,
	input wire logic restoreLoad,
	input wire logic devResetReq,
	input wire logic [20:0] pcNext,
	output logic [20:0] progCnt,
	output logic [2:0] seen
);
	initial
	begin
		seqValid = 1'b0;
		seqOp = ras_pkg::RAS_OP_NONE;
		seqPc = 21'h000000;
		progCnt = 21'h1FFFFF;
		seen = 3'h0;
	end
	// Program counter follows every load, including reset and vectors.
	always @(posedge ref_clk)
		if (pcLoad)
			progCnt <= pcNext;
	// The released PC bus shows the inverse so a stale value never passes.
	task automatic issue(input ras_pkg::ras_op_t op, input logic [20:0] pc);
		@(posedge ref_clk);
		seqValid <= 1'b1;
		seqOp <= op;
		seqPc <= pc;
		@(posedge ref_clk);
		seqValid <= 1'b0;
		seqOp <= ras_pkg::RAS_OP_NONE;
		seqPc <= ~pc;
		#1;
		seen = {pcLoad, restoreLoad, devResetReq};
	endtask
	// Two requests on consecutive edges; the answers seen are those of the second.
	task automatic issuePair(input ras_pkg::ras_op_t op1, input logic [20:0] pc1,
		input ras_pkg::ras_op_t op2, input logic [20:0] pc2);
		@(posedge ref_clk);
		seqValid <= 1'b1;
		seqOp <= op1;
		seqPc <= pc1;
		@(posedge ref_clk);
		seqOp <= op2;
		seqPc <= pc2;
		@(posedge ref_clk);
		seqValid <= 1'b0;
		seqOp <= ras_pkg::RAS_OP_NONE;
		seqPc <= ~pc2;
		#1;
		seen = {pcLoad, restoreLoad, devResetReq};
	endtask
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk, nrst, sysReset, wbCyc, wbStb, wbWe, wbAck, ack;
	logic [7:0] wbAdr, stat, work, bank, statO, workO, bankO;
	logic [31:0] wbDat, wbDatO;
	logic seqValid, pcLoad, restoreLoad, devResetReq;
	ras_pkg::ras_op_t seqOp;
	logic [20:0] seqPc, pcNext, progCnt, fetchAddr;
	logic [15:0] romData, fetchData;
	logic [2:0] seen;
	int miscompares = 0;
	int nCompared = 0;
	ras_return_address_stack u_dut (.ref_clk(ref_clk), .nrst(nrst), .sysReset(sysReset),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(4'h1), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.seqValid(seqValid), .seqOp(seqOp), .seqPc(seqPc), .statusIn(stat),
		.workIn(work), .bankIn(bank), .pcLoad(pcLoad), .pcNext(pcNext),
		.restoreLoad(restoreLoad), .statusOut(statO), .workOut(workO),
		.bankOut(bankO), .devResetReq(devResetReq), .fetchAddr(fetchAddr),
		.romData(romData), .fetchData(fetchData));
	ras_seq_model u_seq (.ref_clk(ref_clk), .seqValid(seqValid), .seqOp(seqOp),
		.seqPc(seqPc), .pcLoad(pcLoad), .restoreLoad(restoreLoad),
		.devResetReq(devResetReq), .pcNext(pcNext), .progCnt(progCnt), .seen(seen));
	// A 50 ns clock.
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic final_report();
		$display("compared %0d, mismatched %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
		nCompared++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", w, e, s);
		end
	endtask
	// Classic single cycle; ack is looked at once it has settled after the edge
	// that raises it, and the request is dropped at the next edge while ack stands.
	// The wait is bounded so a dead slave cannot hang us.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n = 0;
		@(posedge ref_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDat <= d;
		do
		begin
			@(posedge ref_clk);
			#1;
			n++;
			ack = wbAck;
		end while (ack !== 1'b1 && n < 50);
		q = wbDatO;
		@(posedge ref_clk);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		chk("bus ack", {31'h0, ack}, 32'h1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(w, q, {24'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, {24'h0, d}, q);
	endtask
	task automatic pcChk(input logic [20:0] e, input logic [2:0] s);
		chk("pc next", {11'h0, pcNext}, {11'h0, e});
		chk("answer pulses", {29'h0, seen}, {29'h0, s});
	endtask
	// A run still going after 20000 clocks ends through the common closing task.
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		final_report();
	end
	// Main sequence; no sequencer request overlaps a top-byte edit.
	initial
	begin
		{nrst, sysReset, wbCyc, wbStb, wbWe, wbAdr, wbDat} = '0;
		{stat, work, bank, romData, fetchAddr} = '0;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(ras_pkg::OFF_POINTER, 8'h00, "pointer reset");
		rd(ras_pkg::OFF_CONFIG, 8'h01, "config reset");
		rd(8'h20, 8'h00, "unmapped");
		chk("reset pc", {11'h0, progCnt}, 32'h0);
		$display("test reset done");
		u_seq.issue(ras_pkg::RAS_OP_CALL, 21'h012344);
		rd(ras_pkg::OFF_POINTER, 8'h01, "pointer after call");
		rd(ras_pkg::OFF_TOP_UPPER, 8'h01, "top upper");
		rd(ras_pkg::OFF_TOP_HIGH, 8'h23, "top high");
		wr(ras_pkg::OFF_TOP_LOW, 8'h56);
		u_seq.issue(ras_pkg::RAS_OP_RETURN, 21'h0);
		pcChk(21'h012356, 3'b100);
		rd(ras_pkg::OFF_POINTER, 8'h00, "pointer after return");
		$display("test call return done");
		u_seq.issue(ras_pkg::RAS_OP_RETURN, 21'h0);
		pcChk(21'h0, 3'b101);
		@(posedge ref_clk);
		sysReset <= 1'b1;
		@(posedge ref_clk);
		sysReset <= 1'b0;
		rd(ras_pkg::OFF_POINTER, 8'h40, "underflow kept");
		wr(ras_pkg::OFF_POINTER, 8'h00);
		rd(ras_pkg::OFF_POINTER, 8'h00, "underflow cleared");
		$display("test underflow done");
		wr(ras_pkg::OFF_CONFIG, 8'h00);
		for (int i = 1; i <= 31; i++)
			u_seq.issue(ras_pkg::RAS_OP_CALL, 21'(2 * i));
		chk("no reset request", {29'h0, seen}, 32'h0);
		rd(ras_pkg::OFF_POINTER, 8'h9F, "full at 31");
		u_seq.issue(ras_pkg::RAS_OP_CALL, 21'h001000);
		rd(ras_pkg::OFF_POINTER, 8'h9F, "stuck at 31");
		rd(ras_pkg::OFF_TOP_LOW, 8'h3E, "31st kept");
		wr(ras_pkg::OFF_CONFIG, 8'h01);
		wr(ras_pkg::OFF_POINTER, 8'h1E);
		u_seq.issue(ras_pkg::RAS_OP_CALL, 21'h000100);
		chk("full reset req", {31'h0, seen[0]}, 32'h1);
		rd(ras_pkg::OFF_POINTER, 8'h80, "full then zero");
		wr(ras_pkg::OFF_POINTER, 8'h9F);
		rd(ras_pkg::OFF_TOP_LOW, 8'h02, "pc plus two");
		wr(ras_pkg::OFF_POINTER, 8'h00);
		u_seq.issue(ras_pkg::RAS_OP_POP, 21'h0);
		chk("underflow reset req", {31'h0, seen[0]}, 32'h1);
		rd(ras_pkg::OFF_POINTER, 8'h40, "underflow flag");
		wr(ras_pkg::OFF_POINTER, 8'h00);
		$display("test full done");
		{stat, work, bank} <= 24'hA1B2C3;
		u_seq.issue(ras_pkg::RAS_OP_INT_LOW, 21'h000200);
		pcChk(ras_pkg::LOW_VECTOR, 3'b100);
		{stat, work, bank} <= 24'h112233;
		u_seq.issue(ras_pkg::RAS_OP_INT_HIGH, 21'h000300);
		pcChk(ras_pkg::HIGH_VECTOR, 3'b100);
		{stat, work, bank} <= 24'h000000;
		u_seq.issue(ras_pkg::RAS_OP_RETURN_FAST, 21'h0);
		pcChk(21'h000300, 3'b110);
		chk("shadow high", {8'h0, statO, workO, bankO}, 32'h112233);
		{stat, work, bank} <= 24'h445566;
		u_seq.issue(ras_pkg::RAS_OP_CALL_FAST, 21'h000400);
		{stat, work, bank} <= 24'h000000;
		u_seq.issue(ras_pkg::RAS_OP_RETURN, 21'h0);
		pcChk(21'h000400, 3'b100);
		chk("shadow kept", {8'h0, statO, workO, bankO}, 32'h112233);
		u_seq.issue(ras_pkg::RAS_OP_RETURN_FAST, 21'h0);
		pcChk(21'h000200, 3'b110);
		chk("shadow call", {8'h0, statO, workO, bankO}, 32'h445566);
		{stat, work, bank} <= 24'h778899;
		u_seq.issuePair(ras_pkg::RAS_OP_INT_LOW, 21'h000500, ras_pkg::RAS_OP_RETURN_FAST, 21'h0);
		pcChk(21'h000500, 3'b110);
		chk("shadow back to back", {8'h0, statO, workO, bankO}, 32'h778899);
		{stat, work, bank} <= 24'h000000;
		$display("test shadow done");
		u_seq.issue(ras_pkg::RAS_OP_PUSH, 21'h000ABC);
		chk("push no jump", {29'h0, seen}, 32'h0);
		u_seq.issue(ras_pkg::RAS_OP_PUSH, 21'h000DEF);
		u_seq.issue(ras_pkg::RAS_OP_POP, 21'h0);
		chk("pop no jump", {29'h0, seen}, 32'h0);
		rd(ras_pkg::OFF_POINTER, 8'h01, "pointer after pop");
		rd(ras_pkg::OFF_TOP_LOW, 8'hBC, "previous top");
		u_seq.issue(ras_pkg::RAS_OP_POP, 21'h0);
		$display("test push pop done");
		@(posedge ref_clk);
		romData <= 16'hABCD;
		fetchAddr <= 21'h007FFE;
		@(posedge ref_clk);
		fetchAddr <= ras_pkg::IMPL_BYTES;
		#1;
		chk("fetch inside", {16'h0, fetchData}, 32'h0000ABCD);
		@(posedge ref_clk);
		#1;
		chk("fetch beyond", {16'h0, fetchData}, 32'h0);
		$display("test fetch done");
		final_report();
	end
endmodule
`default_nettype wire
